/* pma_pkg.sv */
// Purpose: shared constants and types for the power monitor alert logic
// Assumes: 250 MHz system clock, classic wishbone register access
// Notes: register word offsets are byte addresses
package pma_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SETTLE_US = 300;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned TICK_DIV = 250;

  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_ADC_CONFIG = 8'h04;
  localparam logic [7:0] OFS_DIAG = 8'h08;
  localparam logic [7:0] OFS_CUR_LOW = 8'h0c;
  localparam logic [7:0] OFS_CUR_HIGH = 8'h10;
  localparam logic [7:0] OFS_BUS_HIGH = 8'h14;
  localparam logic [7:0] OFS_BUS_LOW = 8'h18;
  localparam logic [7:0] OFS_TEMP_HIGH = 8'h1c;
  localparam logic [7:0] OFS_PWR_HIGH = 8'h20;
  localparam logic [7:0] OFS_ELAPSED = 8'h24;

  localparam logic [15:0] RST_CUR_LOW = 16'h8000;
  localparam logic [15:0] RST_CUR_HIGH = 16'h7fff;
  localparam logic [15:0] RST_BUS_HIGH = 16'h7fff;
  localparam logic [15:0] RST_BUS_LOW = 16'h0000;
  localparam logic [15:0] RST_TEMP_HIGH = 16'hffff;
  localparam logic [15:0] RST_PWR_HIGH = 16'h7fff;

  // diagnostic register bit positions, and the config register reset bit
  localparam int unsigned B_LATCH = 15;
  localparam int unsigned B_RDYEN = 14;
  localparam int unsigned B_AVG = 13;
  localparam int unsigned B_POL = 12;
  localparam int unsigned B_ENOF = 11;
  localparam int unsigned B_CHOF = 10;
  localparam int unsigned B_ARITH_OVERFLOW_FLAG = 9;
  localparam int unsigned B_MEMOK = 8;
  localparam int unsigned B_CURLO = 7;
  localparam int unsigned B_CURHI = 6;
  localparam int unsigned B_BUSHI = 5;
  localparam int unsigned B_BUSLO = 4;
  localparam int unsigned B_TMPHI = 3;
  localparam int unsigned B_PWRHI = 2;
  localparam int unsigned B_RDY = 1;
  localparam int unsigned B_RESET = 15;

  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_TRIGGERED = 2'b01,
    MODE_CONTINUOUS = 2'b10
  } pma_mode_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } pma_state_t;

  typedef struct packed {
    logic [15:0] current;
    logic [15:0] bus;
    logic [15:0] temp;
    logic [15:0] power;
  } pma_result_t;

  typedef struct packed {
    logic energy_of;
    logic charge_of;
    logic math_of;
    logic mem_ok;
  } pma_health_t;
endpackage

/* pma_alert.sv */
// Purpose: limit comparison, diagnostic flags, alert pin, mode sequencing
// Assumes: wishbone classic slave, results and health flags from the engine
// Notes: ack comes one cycle after request, held one cycle
// Behaviour
// RL1: results treated unsettled for 300 us; limit flags still update, only conversion start waits
// RL2: oscillator clocks conversions and elapsed count
// RL3: compare each result against its limit
// RL4: each diagnostic has flag and threshold
// RL5: thresholds reset to documented default values
// RL6: diagnostic register shows cause and configuration
// RL7: latch holds alert after conditions clear
// RL8: diagnostic read releases latched alert
// RL9: ready enable asserts alert on completion
// RL10: ready flag set on every conversion
// RL11: averaged compare uses averaged results only
// RL12: open drain alert, polarity bit inverts
// RL13: overflow and memory flags never alert
// RL14: arithmetic overflow sets its flag
// RL15: memory flag reads one when intact
// RL16: separate energy and charge overflow flags
// RL17: registers usable while in shutdown
// RL18: shutdown held until conversion command
// RL19: triggered conversion returns to shutdown
// RL20: power-on reset restores all defaults
// RL21: reset bit restores register defaults
// RL22: ready flag cleared by config write, diag read; only a converter config write of a non-shutdown mode or a reset-bit config write clears it
// RL23: unlatched alert follows active diagnostics
// RL24: controller reads diagnostics after each alert
`timescale 1ns/1ps
`default_nettype none
// register map, byte offsets on the wishbone port
// 0x00 config: bit 15 restores register defaults
// 0x04 converter config: mode in bits 1:0
//   0 shutdown, 1 triggered, 2 continuous, 3 read as continuous
// 0x08 diagnostic status and alert configuration
//   15 alert_latch_enable (rw)
//   14 ready_alert_enable (rw)
//   13 averaged_compare_enable (rw)
//   12 alert_polarity_select (rw)
//   11 energy_overflow_flag, sticky until diagnostic read
//   10 charge_overflow_flag, sticky until diagnostic read
//   9 arith_overflow_flag, sticky until diagnostic read
//   8 trim_memory_ok_flag, follows the engine level
//   7 current_low_flag
//   6 current_high_flag
//   5 bus_high_flag
//   4 bus_low_flag
//   3 temp_high_flag
//   2 power_high_flag
//   1 ready_status_flag
// 0x0c current_low_threshold, signed
// 0x10 current high threshold, signed
// 0x14 bus_high_threshold, positive only
// 0x18 bus_low_threshold, positive only
// 0x1c temperature threshold, positive only
// 0x20 power_high_threshold, signed
// 0x24 elapsed microseconds, counted in continuous mode only
// limit flags follow the latest valid result set, in any mode
// a diagnostic read in the same cycle as an event
//   loses to the event, so no flag or latch is missed
// ack is registered: one cycle after the request, one cycle wide
// the alert pin only ever pulls low; alert_o is tied to zero
module pma_alert #(
  parameter int unsigned SETTLE_CYCLES = pma_pkg::SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pma_pkg::pma_result_t sample_i,
  input wire pma_pkg::pma_result_t average_i,
  input wire logic sample_valid_i,
  input wire logic average_valid_i,
  input wire pma_pkg::pma_health_t health_i,
  output logic conv_start_o,
  output logic conv_run_o,
  output logic result_settled_o,
  output logic time_tick_o,
  output logic alert_oe_o,
  output logic alert_o
);
  import pma_pkg::*;

  logic [15:0] thr_reg [6];
  logic [15:0] thr_next [6];
  logic [5:0] ctl_reg, ctl_next;          // latch, rdyen, avg, pol
  pma_mode_t mode_reg, mode_next;
  pma_state_t st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [7:0] div_reg, div_next;
  logic [31:0] elapsed_reg, elapsed_next;
  logic [5:0] lim_reg, lim_next;
  logic [3:0] hl_reg, hl_next;
  logic rdy_reg, rdy_next;
  logic rdy_evt_reg, rdy_evt_next;
  logic latched_reg, latched_next;
  logic alert_reg, alert_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic start_reg, start_next;
  logic tick_reg, tick_next;

  logic req, wr, rd, diag_rd, cfg_wr, soft_rst, done, cmp_valid, alert_raw;
  pma_result_t cmp;
  logic [5:0] over;

  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i && wb_sel_i[1:0] == 2'b11;
  assign rd = req && !wb_we_i;
  assign diag_rd = rd && wb_adr_i == OFS_DIAG;
  assign cfg_wr = wr && wb_adr_i == OFS_ADC_CONFIG;
  assign soft_rst = wr && wb_adr_i == OFS_CONFIG && wb_dat_i[B_RESET];  // [RL21]
  assign done = st_reg == ST_CONV && (ctl_reg[3] ? average_valid_i : sample_valid_i);

  // averaged compare takes only the averaged results [RL11]
  assign cmp = ctl_reg[3] ? average_i : sample_i;
  assign cmp_valid = ctl_reg[3] ? average_valid_i : sample_valid_i;

  // signed limits; bus and temperature thresholds are positive-only [RL3] [RL4]
  always_comb begin
    over[5] = $signed(cmp.current) < $signed(thr_reg[0]);
    over[4] = $signed(cmp.current) > $signed(thr_reg[1]);
    over[3] = cmp.bus > thr_reg[2];
    over[2] = cmp.bus < thr_reg[3];
    over[1] = cmp.temp > thr_reg[4];
    over[0] = $signed(cmp.power) > $signed(thr_reg[5]);
  end

  // health flags stay out of the alert term [RL13] [RL23] [RL9]
  assign alert_raw = (|lim_next) || (ctl_reg[4] && rdy_evt_next);

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      thr_next[i] = thr_reg[i];
    end
    ctl_next = ctl_reg;
    mode_next = mode_reg;
    st_next = st_reg;
    cnt_next = cnt_reg;
    div_next = div_reg;
    elapsed_next = elapsed_reg;
    lim_next = lim_reg;
    hl_next = hl_reg;
    rdy_next = rdy_reg;
    rdy_evt_next = 1'b0;
    latched_next = latched_reg;
    start_next = 1'b0;
    tick_next = 1'b0;
    ack_next = req;
    dat_next = 32'h0;

    // time base for conversions and elapsed count [RL2]
    if (div_reg == 8'(TICK_DIV - 1)) begin
      div_next = 8'h00;
      tick_next = 1'b1;
      if (mode_reg == MODE_CONTINUOUS && st_reg == ST_CONV) begin
        elapsed_next = elapsed_reg + 32'h1;
      end
    end else begin
      div_next = div_reg + 8'h01;
    end

    // bus reads work in every mode, shutdown included [RL17]
    if (rd) begin
      if (wb_adr_i == OFS_ADC_CONFIG) begin
        dat_next = {30'h0, mode_reg};
      end else if (wb_adr_i == OFS_DIAG) begin
        dat_next = {16'h0, ctl_reg[5:2], hl_reg, lim_reg, rdy_reg, 1'b0};  // [RL6]
      end else if (wb_adr_i == OFS_CUR_LOW) begin
        dat_next = {16'h0, thr_reg[0]};
      end else if (wb_adr_i == OFS_CUR_HIGH) begin
        dat_next = {16'h0, thr_reg[1]};
      end else if (wb_adr_i == OFS_BUS_HIGH) begin
        dat_next = {16'h0, thr_reg[2]};
      end else if (wb_adr_i == OFS_BUS_LOW) begin
        dat_next = {16'h0, thr_reg[3]};
      end else if (wb_adr_i == OFS_TEMP_HIGH) begin
        dat_next = {16'h0, thr_reg[4]};
      end else if (wb_adr_i == OFS_PWR_HIGH) begin
        dat_next = {16'h0, thr_reg[5]};
      end else if (wb_adr_i == OFS_ELAPSED) begin
        dat_next = elapsed_reg;
      end else begin
        dat_next = 32'h0;
      end
    end

    if (wr) begin
      if (wb_adr_i == OFS_DIAG) begin
        ctl_next = {wb_dat_i[B_LATCH], wb_dat_i[B_RDYEN], wb_dat_i[B_AVG],
                    wb_dat_i[B_POL], 2'b00};
      end else if (wb_adr_i == OFS_CUR_LOW) begin
        thr_next[0] = wb_dat_i[15:0];  // [RL4]
      end else if (wb_adr_i == OFS_CUR_HIGH) begin
        thr_next[1] = wb_dat_i[15:0];
      end else if (wb_adr_i == OFS_BUS_HIGH) begin
        thr_next[2] = wb_dat_i[15:0];
      end else if (wb_adr_i == OFS_BUS_LOW) begin
        thr_next[3] = wb_dat_i[15:0];
      end else if (wb_adr_i == OFS_TEMP_HIGH) begin
        thr_next[4] = wb_dat_i[15:0];
      end else if (wb_adr_i == OFS_PWR_HIGH) begin
        thr_next[5] = wb_dat_i[15:0];
      end
    end

    // conversion sequencing
    case (st_reg)
      ST_SETTLE: begin
        // conversion start held off until oscillator and converter settle; limit flags still update [RL1]
        if (cnt_reg >= SETTLE_CYCLES - 1) begin
          st_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg + 32'h1;
        end
      end
      ST_IDLE: begin
        // shutdown holds until a conversion command [RL18]
        if (mode_reg != MODE_SHUTDOWN) begin
          st_next = ST_CONV;
          start_next = 1'b1;
        end
      end
      ST_CONV: begin
        if (done) begin
          rdy_evt_next = 1'b1;
          if (mode_reg == MODE_TRIGGERED) begin
            mode_next = MODE_SHUTDOWN;  // [RL19]
            st_next = ST_IDLE;
          end else begin
            start_next = 1'b1;
          end
        end else if (mode_reg == MODE_SHUTDOWN) begin
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase

    // a mode write aborts any conversion in progress; a non-shutdown mode starts a new one
    if (cfg_wr) begin
      mode_next = pma_mode_t'(wb_wdat_mode(wb_dat_i));
      if (st_reg != ST_SETTLE) begin
        st_next = ST_IDLE;
      end
    end

    if (cmp_valid) begin
      lim_next = over;  // [RL3]
    end
    // overflow flags set by events, sticky until diag read; set wins [RL14] [RL16]
    hl_next[3] = health_i.energy_of || (hl_reg[3] && !diag_rd);
    hl_next[2] = health_i.charge_of || (hl_reg[2] && !diag_rd);
    hl_next[1] = health_i.math_of || (hl_reg[1] && !diag_rd);
    hl_next[0] = health_i.mem_ok;  // [RL15]

    // ready flag set on every completion, set wins over clear [RL10] [RL22]
    if (rdy_evt_next) begin
      rdy_next = 1'b1;
    end else if (diag_rd || (cfg_wr && wb_dat_i[1:0] != MODE_SHUTDOWN)) begin
      rdy_next = 1'b0;
    end

    // latch holds alert until diagnostic read [RL7] [RL8]
    if (alert_raw && ctl_reg[5]) begin
      latched_next = 1'b1;
    end else if (diag_rd || !ctl_reg[5]) begin
      latched_next = 1'b0;
    end

    // soft reset restores register defaults [RL21]
    if (soft_rst) begin
      thr_next[0] = RST_CUR_LOW;
      thr_next[1] = RST_CUR_HIGH;
      thr_next[2] = RST_BUS_HIGH;
      thr_next[3] = RST_BUS_LOW;
      thr_next[4] = RST_TEMP_HIGH;
      thr_next[5] = RST_PWR_HIGH;
      ctl_next = 6'h00;
      mode_next = MODE_SHUTDOWN;
      st_next = (st_reg == ST_SETTLE) ? ST_SETTLE : ST_IDLE;
      lim_next = 6'h00;
      hl_next[3:1] = 3'b000;
      rdy_next = 1'b0;
      latched_next = 1'b0;
      elapsed_next = 32'h0;
    end
  end

  function automatic logic [1:0] wb_wdat_mode(input logic [31:0] d);
    wb_wdat_mode = (d[1:0] == 2'b11) ? 2'b10 : d[1:0];
  endfunction

  // asserted level is internal; pin pulled low when active-low asserts [RL12]
  always_comb begin
    alert_next = alert_raw || latched_next;  // [RL23]
  end

  // all state back to defaults on reset [RL20]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      thr_reg[0] <= RST_CUR_LOW;  // [RL5]
      thr_reg[1] <= RST_CUR_HIGH;
      thr_reg[2] <= RST_BUS_HIGH;
      thr_reg[3] <= RST_BUS_LOW;
      thr_reg[4] <= RST_TEMP_HIGH;
      thr_reg[5] <= RST_PWR_HIGH;
      ctl_reg <= 6'h00;
      mode_reg <= MODE_SHUTDOWN;
      st_reg <= ST_SETTLE;
      cnt_reg <= 32'h0;
      div_reg <= 8'h00;
      elapsed_reg <= 32'h0;
      lim_reg <= 6'h00;
      hl_reg <= 4'h0;
      rdy_reg <= 1'b0;
      rdy_evt_reg <= 1'b0;
      latched_reg <= 1'b0;
      alert_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
      start_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        thr_reg[i] <= thr_next[i];
      end
      ctl_reg <= ctl_next;
      mode_reg <= mode_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      elapsed_reg <= elapsed_next;
      lim_reg <= lim_next;
      hl_reg <= hl_next;
      rdy_reg <= rdy_next;
      rdy_evt_reg <= rdy_evt_next;
      latched_reg <= latched_next;
      alert_reg <= alert_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
      start_reg <= start_next;
      tick_reg <= tick_next;
    end
  end

  // open drain: enable low drive when asserted and active-low, else when idle with pol [RL12]
  logic oe_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= alert_next ^ ctl_next[2];
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign conv_start_o = start_reg;
  assign time_tick_o = tick_reg;
  assign alert_o = 1'b0;
  assign alert_oe_o = oe_reg;
  assign conv_run_o = rdy_evt_reg;
  assign result_settled_o = alert_reg;
endmodule
`default_nettype wire

/* pma_alert_sva.sv */
// Purpose: port checks for the alert block
// Assumes: one clock, synchronous reset
// Notes: polarity shadow tracks bus writes
`timescale 1ns/1ps
`default_nettype none
module pma_alert_sva #(
  parameter int unsigned SETTLE_CYCLES = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic conv_start_o,
  input wire logic conv_run_o,
  input wire logic result_settled_o,
  input wire logic time_tick_o,
  input wire logic alert_oe_o,
  input wire logic alert_o
);
  import pma_pkg::*;
  logic [31:0] settle_reg;
  logic pol_reg;
  logic wr_hit;
  assign wr_hit = !wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[1:0] == 2'b11;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      settle_reg <= 32'h0;
      pol_reg <= 1'b0;
    end else begin
      if (settle_reg < SETTLE_CYCLES) settle_reg <= settle_reg + 32'h1;
      if (wr_hit && wb_adr_i == OFS_DIAG) pol_reg <= wb_dat_i[B_POL];
      if (wr_hit && wb_adr_i == OFS_CONFIG && wb_dat_i[B_RESET]) pol_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i > OFS_ELAPSED
    && !wb_ack_o |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  open_drain_a: assert property (alert_o == 1'b0)
    else $error("alert pin driven high");
  pin_polarity_a: assert property (pol_reg == $past(pol_reg, 2) |->
    alert_oe_o == (result_settled_o ^ pol_reg)) else $error("alert enable wrong");
  settle_block_a: assert property (conv_start_o |-> settle_reg >= SETTLE_CYCLES - 1)
    else $error("conversion before settling");
  reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !alert_oe_o && !conv_start_o)
    else $error("outputs active after reset");
  run_pulse_a: assert property (conv_run_o |=> !conv_run_o)
    else $error("completion pulse too long");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  tick_gap_a: assert property (time_tick_o |=> !time_tick_o [*8])
    else $error("time ticks too close");
endmodule
`default_nettype wire

/* pma_ctrl_model.sv */
// Purpose: controller side of the alert wire
// Assumes: external pull-up on the line
// Notes: reports the resolved line level
`timescale 1ns/1ps
`default_nettype none
module pma_ctrl_model (
  input wire logic alert_oe_i,
  input wire logic alert_i,
  output logic alert_line_o
);
  // released pin floats to the pull-up level
  assign alert_line_o = alert_oe_i ? alert_i : 1'b1;
endmodule
`default_nettype wire

/* testbench.sv */
// Purpose: self-checking bench for the alert block
// Assumes: classic wishbone, short settle parameter
// Notes: read results checked from a queue
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pma_pkg::*;
  localparam int unsigned SETTLE_CYCLES = 20;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, sample_valid_i, average_valid_i;
  logic conv_start_o, conv_run_o, result_settled_o, time_tick_o, alert_oe_o, alert_o;
  logic alert_line, low_seen, start_seen;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [63:0] note;
  logic [63:0] exp_q[$];
  logic [15:0] val;
  pma_result_t sample_i, average_i;
  pma_health_t health_i;
  int mismatches, n_tests, cycles;
  integer seed;
  logic [7:0] ofs[6] = '{OFS_CUR_LOW, OFS_CUR_HIGH, OFS_BUS_HIGH, OFS_BUS_LOW, OFS_TEMP_HIGH,
    OFS_PWR_HIGH};
  logic [15:0] rv[6] = '{RST_CUR_LOW, RST_CUR_HIGH, RST_BUS_HIGH, RST_BUS_LOW, RST_TEMP_HIGH,
    RST_PWR_HIGH};
  pma_alert #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_i(sample_i), .average_i(average_i), .sample_valid_i(sample_valid_i),
    .average_valid_i(average_valid_i), .health_i(health_i), .conv_start_o(conv_start_o),
    .conv_run_o(conv_run_o), .result_settled_o(result_settled_o), .time_tick_o(time_tick_o),
    .alert_oe_o(alert_oe_o), .alert_o(alert_o));
  pma_ctrl_model i_ctrl (.alert_oe_i(alert_oe_o), .alert_i(alert_o), .alert_line_o(alert_line));
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    input logic [3:0] sel);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (n >= 50) mismatches++;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'h3);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
    exp_q.push_back({mask, exp & mask});
    wb(1'b0, adr, 32'h0, 4'hf);
  endtask
  task automatic smp(input logic [15:0] cur, input logic avg);
    @(posedge clk_i);
    sample_i <= {cur, 48'h0};
    average_i <= {cur, 48'h0};
    sample_valid_i <= !avg;
    average_valid_i <= avg;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
    average_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic defaults();
    for (int i = 0; i < 6; i++) rd(ofs[i], {16'h0, rv[i]}, 32'hffffffff);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (alert_line === 1'b0) low_seen = 1'b1;
    if (conv_start_o === 1'b1) start_seen = 1'b1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      check(wb_dat_o & note[63:32], note[31:0], "read data");
    end
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, sample_valid_i, average_valid_i} = 6'h20;
    {wb_adr_i, wb_sel_i, wb_dat_i, sample_i, average_i} = '0;
    health_i = 4'b0001;
    seed = 32'h0ce5c818;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (SETTLE_CYCLES + 10) @(posedge clk_i);
    defaults();
    rd(OFS_DIAG, 32'h100, 32'h100);
    rd(8'h40, 32'h0, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      val = 16'($random(seed));
      wr(ofs[i], {16'h0, val});
      rd(ofs[i], {16'h0, val}, 32'hffffffff);
    end
    wb(1'b1, ofs[5], 32'h1234, 4'h0);
    rd(ofs[5], {16'h0, val}, 32'hffffffff);
    wr(OFS_CONFIG, 32'h8000);
    defaults();
    repeat (SETTLE_CYCLES + 10) @(posedge clk_i);
    wr(OFS_TEMP_HIGH, 32'h7fff);
    wr(OFS_CUR_HIGH, 32'h0100);
    smp(16'h0200, 1'b0);
    check(alert_line, 1'b0, "alert over");
    rd(OFS_DIAG, 32'h40, 32'h40);
    smp(16'h0050, 1'b0);
    check(alert_line, 1'b1, "alert cleared");
    wr(OFS_DIAG, 32'h1 << B_AVG);
    smp(16'h0200, 1'b0);
    check(alert_line, 1'b1, "single sample");
    smp(16'h0200, 1'b1);
    check(alert_line, 1'b0, "averaged over");
    smp(16'h0050, 1'b1);
    wr(OFS_DIAG, 32'h1 << B_LATCH);
    smp(16'h0200, 1'b0);
    smp(16'h0050, 1'b0);
    check(alert_line, 1'b0, "latched alert");
    rd(OFS_DIAG, 32'h8000, 32'h8000);
    repeat (4) @(posedge clk_i);
    check(alert_line, 1'b1, "latch released");
    wr(OFS_DIAG, 32'h1 << B_POL);
    repeat (4) @(posedge clk_i);
    check(alert_line, 1'b0, "inverted idle");
    smp(16'h0200, 1'b0);
    check(alert_line, 1'b1, "inverted active");
    smp(16'h0050, 1'b0);
    wr(OFS_DIAG, 32'h0);
    low_seen = 1'b0;
    @(posedge clk_i);
    health_i <= 4'b1111;
    @(posedge clk_i);
    health_i <= 4'b0001;
    repeat (4) @(posedge clk_i);
    check(low_seen, 1'b0, "health alert");
    rd(OFS_DIAG, 32'he00, 32'he00);
    rd(OFS_DIAG, 32'h0, 32'he00);
    for (int e = 1; e >= 0; e--) begin
      wr(OFS_DIAG, e << B_RDYEN);
      start_seen = 1'b0;
      wr(OFS_ADC_CONFIG, {30'h0, MODE_TRIGGERED});
      for (int n = 0; n < 50 && !start_seen; n++) @(posedge clk_i);
      check(start_seen, 1'b1, "start");
      low_seen = 1'b0;
      smp(16'h0050, 1'b0);
      check(low_seen, e[0], "ready alert");
      rd(OFS_ADC_CONFIG, {30'h0, MODE_SHUTDOWN}, 32'h3);
      rd(OFS_DIAG, 32'h2, 32'h2);
      rd(OFS_DIAG, 32'h0, 32'h2);
    end
    wr(OFS_ADC_CONFIG, {30'h0, MODE_CONTINUOUS});
    smp(16'h0050, 1'b0);
    wr(OFS_ADC_CONFIG, {30'h0, MODE_CONTINUOUS});
    rd(OFS_DIAG, 32'h0, 32'h2);
    wr(OFS_ADC_CONFIG, {30'h0, MODE_SHUTDOWN});
    give_verdict();
  end
endmodule
bind pma_alert pma_alert_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_sva (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o), .conv_run_o(conv_run_o),
  .result_settled_o(result_settled_o), .time_tick_o(time_tick_o), .alert_oe_o(alert_oe_o),
  .alert_o(alert_o));
`default_nettype wire
